/* include/adcrc_defines.svh */
// Constants for the converter reset and interrupt control block.
`ifndef ADCRC_DEFINES_SVH
`define ADCRC_DEFINES_SVH
`define ADCRC_SC_RESET      8'h00
`define ADCRC_CTRL_RESET    8'h00
`define ADCRC_PE_RESET      8'h00
`define ADCRC_RESULT_RESET  8'h00
`define ADCRC_SAR_RESET     10'h000
`define ADCRC_SC_IE_BIT     6
`define ADCRC_SC_CH_LSB     0
`define ADCRC_SC_CH_MSB     4
`define ADCRC_CTRL_PU_BIT   7
`define ADCRC_CTRL_DJM_BIT  6
`define ADCRC_CTRL_RES8_BIT 5
`define ADCRC_CTRL_SGN_BIT  4
`define ADCRC_SAR_BITS      10
`define ADCRC_SAMPLE_CYC    5'h0E
`define ADCRC_BITCNT_TOP    4'h9
`define ADCRC_CMP_SETTLE    2'h2
`endif

/* include/adcrc_pkg.sv */
// Types for the converter reset and interrupt control block.
package adcrc_pkg;
    typedef enum logic [1:0] {
        ADCRC_IDLE   = 2'b00,
        ADCRC_SAMPLE = 2'b01,
        ADCRC_CONV   = 2'b10
    } adcrc_state_t;
endpackage

/* rtl/adcrc_ctrl.sv */
// Converter control: reset, abort, result capture and conversion-done interrupt.
// Overview of operation
// - System reset returns every register to its reset value and powers converter down.
// - Power-on control bit resets to zero, so converter starts powered down.
// - Reset stops a running conversion, clears done flag and zeroes the SAR.
// - Reset withdraws any pending converter interrupt request.
// - Setting power-on bit leaves all other register contents unchanged.
// - Control register write resets nothing but ends the running conversion.
// - With interrupts enabled, raise request at conversion end with both results valid.
// - Interrupt request stays asserted while the done flag remains set.
// - Any status/control register write clears the done flag.
// - Reading either result register clears the done flag.
// - Status/control write aborts any running conversion and, with the power-on bit set, starts a new one.
// - Pin-enable register write aborts the conversion without starting another.
// - Clearing the power-on bit aborts any conversion in progress.
`include "adcrc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module adcrc_ctrl
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 wr_status_control_reg,
    input  wire logic                 wr_converter_control_reg,
    input  wire logic                 wr_pin_enable_reg,
    input  wire logic [7:0]           wr_data,
    input  wire logic                 rd_result_high_reg,
    input  wire logic                 rd_result_low_reg,
    input  wire logic                 comparator_high,
    output logic [7:0]                status_control_reg,
    output logic [7:0]                converter_control_reg,
    output logic [7:0]                pin_enable_reg,
    output logic [7:0]                result_high_reg,
    output logic [7:0]                result_low_reg,
    output logic                      conversion_done_flag,
    output logic                      conv_irq,
    output logic                      converter_power_on,
    output logic                      sample_enable,
    output logic [9:0]                sar_trial
);
    import adcrc_pkg::*;

    // The comparator is analog-side; it is synchronised before the SAR reads it.
    logic                 cmp_meta;
    logic                 cmp_sync;
    adcrc_state_t         state;
    adcrc_state_t         next_state;
    logic [4:0]           cnt;
    logic [4:0]           next_cnt;
    logic [9:0]           sar;
    logic [9:0]           next_sar;
    logic [9:0]           bitmask;
    logic [9:0]           next_bitmask;

    // Phase within one bit (0 to 2): trial out, first flop, then second flop and decide.
    logic [1:0]           ph;
    logic [1:0]           next_ph;

    logic [7:0]           next_sc;
    logic [7:0]           next_ctrl;
    logic [7:0]           next_pe;
    logic [7:0]           next_rh;
    logic [7:0]           next_rl;
    logic                 next_done;
    logic                 next_irq;
    logic                 next_sample;
    logic                 abort;
    logic                 start;
    logic                 finish;
    logic [9:0]           res;

    always_ff @(posedge clk_sys) begin
        cmp_meta <= comparator_high;
        cmp_sync <= cmp_meta;
    end

    // Register file. Each write is a plain store and touches no other register,
    // so powering up keeps whatever software set before.
    always_comb begin
        next_sc   = status_control_reg;
        next_ctrl = converter_control_reg;
        next_pe   = pin_enable_reg;

        if (wr_status_control_reg) begin
            next_sc = wr_data;
        end

        if (wr_converter_control_reg) begin
            next_ctrl = wr_data;
        end

        if (wr_pin_enable_reg) begin
            next_pe = wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_control_reg    <= `ADCRC_SC_RESET;
            converter_control_reg <= `ADCRC_CTRL_RESET;
            pin_enable_reg        <= `ADCRC_PE_RESET;
            converter_power_on    <= 1'b0;
        end else begin
            status_control_reg    <= next_sc;
            converter_control_reg <= next_ctrl;
            pin_enable_reg        <= next_pe;
            converter_power_on    <= next_ctrl[`ADCRC_CTRL_PU_BIT];
        end
    end

    // Write decode. Every register write ends the running conversion; only a
    // status write starts one, and a control write in the same cycle vetoes it.
    always_comb begin
        abort = wr_status_control_reg;

        if (wr_pin_enable_reg) begin
            abort = 1'b1;
        end

        if (wr_converter_control_reg) begin
            abort = 1'b1;
        end

        if (wr_converter_control_reg && !wr_data[`ADCRC_CTRL_PU_BIT]) begin
            abort = 1'b1;
        end

        start = wr_status_control_reg && !wr_converter_control_reg;

        // A status write with the converter off is stored but starts nothing.
        if (!converter_control_reg[`ADCRC_CTRL_PU_BIT]) begin
            start = 1'b0;
        end
    end

    // Sequencer. The comparator reaches the SAR through two flops, so each bit
    // holds its trial for three clocks before it is decided. That triples the
    // bit time but keeps a metastable comparator edge away from the SAR.
    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_ph      = ph;
        next_bitmask = bitmask;
        next_sar     = sar;
        finish       = 1'b0;

        unique case (state)
            ADCRC_IDLE: begin
            end

            ADCRC_SAMPLE: begin
                if (cnt == `ADCRC_SAMPLE_CYC) begin
                    next_state   = ADCRC_CONV;
                    next_cnt     = 5'h00;
                    next_ph      = 2'h0;
                    next_bitmask = 10'h200;
                    next_sar     = 10'h200;
                end else begin
                    next_cnt = cnt + 5'h01;
                end
            end

            ADCRC_CONV: begin
                if (ph != `ADCRC_CMP_SETTLE) begin
                    next_ph = ph + 2'h1;
                end else begin
                    next_ph = 2'h0;

                    // Keep the trial bit only if the input is at or above the trial code.
                    if (!cmp_sync) begin
                        next_sar = sar & ~bitmask;
                    end

                    next_bitmask = bitmask >> 1;
                    next_sar     = next_sar | (bitmask >> 1);

                    if (cnt[3:0] == `ADCRC_BITCNT_TOP) begin
                        finish     = 1'b1;
                        next_state = ADCRC_IDLE;
                    end else begin
                        next_cnt = cnt + 5'h01;
                    end
                end
            end

            default: begin
                next_state = ADCRC_IDLE;
            end
        endcase

        // An abort in the last bit cycle wins; the unfinished result is dropped.
        if (abort) begin
            finish       = 1'b0;
            next_state   = ADCRC_IDLE;
            next_cnt     = 5'h00;
            next_ph      = 2'h0;
            next_bitmask = 10'h000;
            next_sar     = `ADCRC_SAR_RESET;
        end

        if (start) begin
            next_state = ADCRC_SAMPLE;
            next_cnt   = 5'h00;
        end

        next_sample = (next_state == ADCRC_SAMPLE);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state         <= ADCRC_IDLE;
            cnt           <= 5'h00;
            ph            <= 2'h0;
            bitmask       <= 10'h000;
            sar           <= `ADCRC_SAR_RESET;
            sar_trial     <= `ADCRC_SAR_RESET;
            sample_enable <= 1'b0;
        end else begin
            state         <= next_state;
            cnt           <= next_cnt;
            ph            <= next_ph;
            bitmask       <= next_bitmask;
            sar           <= next_sar;
            sar_trial     <= next_sar;
            sample_enable <= next_sample;
        end
    end

    // Format the finished conversion into the two result bytes. Both bytes are
    // loaded on the same edge as the flag, so the request never sees stale data.
    always_comb begin
        res = next_sar;
        if (converter_control_reg[`ADCRC_CTRL_SGN_BIT] && !converter_control_reg[`ADCRC_CTRL_DJM_BIT]) begin
            res[9] = ~next_sar[9];
        end

        next_rh = result_high_reg;
        next_rl = result_low_reg;

        if (finish) begin
            if (converter_control_reg[`ADCRC_CTRL_RES8_BIT]) begin
                next_rh = res[9:2];
                next_rl = 8'h00;
            end else if (converter_control_reg[`ADCRC_CTRL_DJM_BIT]) begin
                next_rh = {6'h00, res[9:8]};
                next_rl = res[7:0];
            end else begin
                next_rh = res[9:2];
                next_rl = {res[1:0], 6'h00};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            result_high_reg <= `ADCRC_RESULT_RESET;
            result_low_reg  <= `ADCRC_RESULT_RESET;
        end else begin
            result_high_reg <= next_rh;
            result_low_reg  <= next_rl;
        end
    end

    // Done flag and request. A read in the completing cycle loses to the set,
    // so a fresh result is never missed; a status write always clears, as it aborts.
    always_comb begin
        next_done = conversion_done_flag;

        if (finish) begin
            next_done = 1'b1;
        end

        if ((rd_result_high_reg || rd_result_low_reg) && !finish) begin
            next_done = 1'b0;
        end

        if (wr_status_control_reg) begin
            next_done = 1'b0;
        end

        next_irq = next_done && next_sc[`ADCRC_SC_IE_BIT];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            conversion_done_flag <= 1'b0;
            conv_irq             <= 1'b0;
        end else begin
            conversion_done_flag <= next_done;
            conv_irq             <= next_irq;
        end
    end
endmodule
`default_nettype wire

/* tb/adcrc_cmp_model.sv */
// Behavioural analog comparator facing the trial code of the converter.
`timescale 1ns/1ps
`default_nettype none
module adcrc_cmp_model
(
    input  wire logic [9:0] sar_trial,
    input  wire logic [9:0] vin,
    output logic            comparator_high
);
    // The input is held steady for a whole conversion; only the trial code moves.
    assign comparator_high = (vin >= sar_trial);
endmodule
`default_nettype wire

/* tb/adcrc_ctrl_sva.sv */
// Concurrent checks on the ports of the converter control block.
`include "adcrc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module adcrc_ctrl_sva
(
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       wr_status_control_reg,
    input wire logic       wr_converter_control_reg,
    input wire logic       wr_pin_enable_reg,
    input wire logic       rd_result_high_reg,
    input wire logic       rd_result_low_reg,
    input wire logic [7:0] status_control_reg,
    input wire logic [7:0] pin_enable_reg,
    input wire logic [7:0] result_high_reg,
    input wire logic       conversion_done_flag,
    input wire logic       conv_irq,
    input wire logic       converter_power_on,
    input wire logic       sample_enable,
    input wire logic [9:0] sar_trial
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_irq_and_flag: assert property (conv_irq == (conversion_done_flag && status_control_reg[`ADCRC_SC_IE_BIT]))
        else $error("irq differs from flag and enable");
    a_reset_clears: assert property (disable iff (1'b0) rst |=> !conversion_done_flag && !conv_irq &&
        sar_trial == 10'h000 && !converter_power_on && !sample_enable) else $error("reset left state behind");
    a_sc_write_clear: assert property (wr_status_control_reg |=> !conversion_done_flag)
        else $error("flag survived status write");
    a_read_clear: assert property ((rd_result_high_reg || rd_result_low_reg) && conversion_done_flag
        |=> !conversion_done_flag) else $error("flag survived result read");
    a_done_timing: assert property ($rose(conversion_done_flag) |-> $past(sample_enable, 31) &&
        !$past(sample_enable, 30)) else $error("flag rose off the conversion end");
    a_sc_starts: assert property (wr_status_control_reg && !wr_converter_control_reg && converter_power_on
        |=> sample_enable) else $error("status write did not start");
    a_write_aborts: assert property ((wr_pin_enable_reg || wr_converter_control_reg) && !wr_status_control_reg
        |=> !sample_enable [*2]) else $error("conversion not aborted");
    a_power_keeps: assert property (wr_converter_control_reg && !wr_status_control_reg && !wr_pin_enable_reg
        |=> $stable(status_control_reg) && $stable(pin_enable_reg)) else $error("control write changed registers");
    c_irq: cover property ($rose(conv_irq));
    c_poll: cover property ($rose(conversion_done_flag) && !conv_irq);
    c_abort: cover property (wr_pin_enable_reg && sample_enable);
endmodule
bind adcrc_ctrl adcrc_ctrl_sva i_adcrc_ctrl_sva (.*);
`default_nettype wire

/* tb/adcrc_ctrl_test.sv */
// Self-checking bench for the converter reset and interrupt control block.
`timescale 1ns/1ps
`default_nettype none
module adcrc_ctrl_test;
    logic clk_sys = 0, rst = 1, comparator_high;
    logic [4:0] st = 0;
    logic [7:0] wr_data = 0, status_control_reg, converter_control_reg, pin_enable_reg, result_high_reg, result_low_reg;
    logic conversion_done_flag, conv_irq, converter_power_on, sample_enable;
    logic [9:0] sar_trial, vin = 10'h2C7;
    int errors = 0, n_tests = 0, cyc = 0, lat, n;
    adcrc_ctrl i_adcrc_ctrl (.*, .wr_status_control_reg(st[0]), .wr_converter_control_reg(st[1]),
        .wr_pin_enable_reg(st[2]), .rd_result_high_reg(st[3]), .rd_result_low_reg(st[4]));
    adcrc_cmp_model i_adcrc_cmp_model (.*);
    always #20 clk_sys = ~clk_sys;
    task automatic summarize();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    // Strobe k: 0 status, 1 control, 2 pin enable, 3 high read, 4 low read.
    task automatic pulse(input int k, input logic [7:0] d);
        wr_data = d;
        st = 5'h01 << k;
        tick(1);
        st = 0;
        tick(1);
    endtask
    // Eighty cycles, near twice a conversion, without completion means none is running.
    task automatic wait_done();
        n = 0;
        while (conversion_done_flag !== 1'b1 && n < 80) begin
            tick(1);
            n++;
        end
    endtask
    task automatic t_convert();
        pulse(2, 8'h5A);
        pulse(0, 8'h40);
        pulse(1, 8'h80);
        chk("sc_pe_flag", {status_control_reg, pin_enable_reg, 7'h00, conversion_done_flag}, 24'h405A00);
        pulse(0, 8'h40);
        wait_done();
        lat = n;
        chk("irq_rh_rl", {conv_irq, result_high_reg, result_low_reg}, {1'b1, vin, 6'h00});
        tick(3);
        chk("held", {conversion_done_flag, conv_irq}, 2'b11);
        pulse(3, 8'h00);
        chk("rd_high", {conversion_done_flag, conv_irq}, 2'b00);
    endtask
    task automatic t_poll();
        pulse(0, 8'h00);
        wait_done();
        chk("poll", {conversion_done_flag, conv_irq}, 2'b10);
        pulse(0, 8'h00);
        chk("sc_clear", conversion_done_flag, 0);
        wait_done();
        pulse(4, 8'h00);
        chk("rd_low", conversion_done_flag, 0);
    endtask
    task automatic t_abort(input int k, input logic [7:0] d);
        pulse(0, 8'h40);
        tick(8);
        pulse(k, d);
        pulse(1, 8'h80);
        wait_done();
        chk("abort", n, 80);
    endtask
    task automatic t_format(input logic [7:0] c, input logic [15:0] e);
        pulse(1, c);
        pulse(0, 8'h00);
        wait_done();
        chk("format", {result_high_reg, result_low_reg}, e);
        pulse(3, 8'h00);
    endtask
    initial begin
        tick(20);
        rst = 0;
        chk("reset", {status_control_reg, converter_control_reg, sar_trial, conversion_done_flag}, 0);
        t_convert();
        t_poll();
        t_format(8'hC0, 16'h02C7);
        t_format(8'hA0, 16'hB100);
        t_format(8'h90, 16'h31C0);
        t_abort(2, 8'h5A);
        t_abort(1, 8'h80);
        t_abort(1, 8'h00);
        pulse(0, 8'h40);
        tick(10);
        pulse(0, 8'h40);
        wait_done();
        chk("restart", n, lat);
        pulse(3, 8'h00);
        pulse(0, 8'h40);
        tick(20);
        rst = 1;
        tick(2);
        rst = 0;
        chk("mid_reset", {sar_trial, conversion_done_flag, conv_irq, converter_power_on}, 0);
        summarize();
    end
endmodule
`default_nettype wire
